// File: logic/mcc_pkg.sv
package mcc_pkg;
    // ----------------------------------------
    // Command and register map
    // ----------------------------------------
    localparam logic [2:0] CAL_PREFIX = 3'h6;
    localparam int CAL_PREFIX_HI = 7;
    localparam int CAL_PREFIX_LO = 5;
    localparam logic [4:0] ADDR_DEVICE_CONFIGURATION = 5'h00;
    localparam int CFG_W = 24;
    localparam logic [23:0] CFG_RESET = 24'h00_0001;
    localparam logic [23:0] CFG_WRITABLE = 24'hFF_9FFF;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PC_HI = 23;
    localparam int PC_LO = 17;
    localparam int IGAIN_BIT = 16;
    localparam int OPEN_DRAIN_BIT = 15;
    localparam int IRQ_STYLE_BIT = 12;
    localparam int IRQ_POL_BIT = 11;
    localparam int OVR_EN_BIT = 10;
    localparam int OVR_A_BIT = 9;
    localparam int OVR_B_BIT = 8;
    localparam int SWING_BIT = 7;
    localparam int VOLT_HIGHPASS_EN_BIT = 6;
    localparam int CURR_HIGHPASS_EN_BIT = 5;
    localparam int CLK_INV_BIT = 4;
    localparam int K_HI = 3;
    localparam int K_LO = 0;
    // ----------------------------------------
    // Calibration select codes
    // ----------------------------------------
    localparam logic [4:0] CAL_I_DC_OFF = 5'h09;
    localparam logic [4:0] CAL_I_DC_GAIN = 5'h0A;
    localparam logic [4:0] CAL_I_AC_OFF = 5'h0D;
    localparam logic [4:0] CAL_I_AC_GAIN = 5'h0E;
    localparam logic [4:0] CAL_V_DC_OFF = 5'h11;
    localparam logic [4:0] CAL_V_DC_GAIN = 5'h12;
    localparam logic [4:0] CAL_V_AC_OFF = 5'h15;
    localparam logic [4:0] CAL_V_AC_GAIN = 5'h16;
    localparam logic [4:0] CAL_B_DC_OFF = 5'h19;
    localparam logic [4:0] CAL_B_DC_GAIN = 5'h1A;
    localparam logic [4:0] CAL_B_AC_GAIN = 5'h1D;
    localparam logic [4:0] K_ZERO_MEANS_16 = 5'h10;
endpackage

// File: logic/mcc_config_cal.sv
`timescale 1ns/1ns
`default_nettype none
module mcc_config_cal
    import mcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Decoded serial command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic wr_commit,
    input wire logic [4:0] wr_addr,
    input wire logic [23:0] wr_data,
    output logic [23:0] cfg_rd_data,
    // Calibration handshake with datapath
    output logic cal_start,
    output logic cal_curr,
    output logic cal_volt,
    output logic cal_gain,
    output logic cal_ac,
    input wire logic cal_done,
    input wire logic [23:0] cal_result,
    output logic offset_wr_i,
    output logic offset_wr_v,
    output logic gain_wr_i,
    output logic gain_wr_v,
    output logic [23:0] cal_wr_data,
    output logic result_ready_flag,
    input wire logic result_ready_clr,
    // Configuration fields
    output logic [6:0] phase_comp,
    output logic curr_gain_50x,
    output logic volt_highpass_en,
    output logic curr_highpass_en,
    output logic swinging_pulse_format,
    output logic counter_drive_mode,
    output logic cycle_restart,
    // Clocks
    output logic divided_internal_clk,
    output logic divided_clk_en,
    output logic host_clock_out,
    // Energy pulses from datapath and pins
    input wire logic pulse_a_raw_n,
    input wire logic pulse_b_raw_n,
    output logic energy_pulse_a_n_o,
    output logic energy_pulse_a_n_oe,
    output logic energy_pulse_b_n_o,
    output logic energy_pulse_b_n_oe,
    // Interrupt pin
    input wire logic irq_event,
    output logic irq_pin
);
    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    logic [23:0] cfg_q, cfg_d;
    always_comb begin
        cfg_d = cfg_q;
        if (wr_commit && wr_addr == ADDR_DEVICE_CONFIGURATION) begin
            // Reserved bits are held at zero even if the host misbehaves
            cfg_d = wr_data & CFG_WRITABLE;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    assign cfg_rd_data = cfg_q;
    assign phase_comp = cfg_q[PC_HI:PC_LO];
    assign curr_gain_50x = cfg_q[IGAIN_BIT];
    assign volt_highpass_en = cfg_q[VOLT_HIGHPASS_EN_BIT];
    assign curr_highpass_en = cfg_q[CURR_HIGHPASS_EN_BIT];
    assign swinging_pulse_format = cfg_q[SWING_BIT];
    assign counter_drive_mode = cfg_q[SWING_BIT];

    // ----------------------------------------
    // Calibration decode
    // ----------------------------------------
    function automatic logic cal_known(input logic [4:0] s);
        return s inside {CAL_I_DC_OFF, CAL_I_DC_GAIN, CAL_I_AC_OFF,
            CAL_I_AC_GAIN, CAL_V_DC_OFF, CAL_V_DC_GAIN, CAL_V_AC_OFF,
            CAL_V_AC_GAIN, CAL_B_DC_OFF, CAL_B_DC_GAIN, CAL_B_AC_GAIN};
    endfunction

    // Both-channel AC gain code breaks the gain-bit pattern of the rest
    function automatic logic cal_is_gain(input logic [4:0] s);
        return s[1] || s == CAL_B_AC_GAIN;
    endfunction

    typedef enum logic {ST_IDLE, ST_BUSY} mcc_cal_state_t;
    mcc_cal_state_t st_q, st_d;
    logic [4:0] sel_q, sel_d;
    logic start_q, start_d;
    logic rdy_q, rdy_d;
    logic [3:0] upd_q, upd_d;
    logic [23:0] res_q, res_d;
    logic is_cal;
    logic gsel;
    assign gsel = cal_is_gain(sel_q);
    // Select bits: [4] voltage, [3] current, [2] AC, [1] gain
    assign is_cal = cmd_valid &&
        cmd_byte[CAL_PREFIX_HI:CAL_PREFIX_LO] == CAL_PREFIX;

    always_comb begin
        st_d = st_q;
        sel_d = sel_q;
        start_d = 1'b0;
        upd_d = 4'h0;
        res_d = res_q;
        rdy_d = rdy_q;
        if (result_ready_clr) begin
            rdy_d = 1'b0;
        end
        unique case (st_q)
            ST_IDLE: begin
                // Unlisted codes are dropped, never started
                if (is_cal && cal_known(cmd_byte[4:0])) begin
                    sel_d = cmd_byte[4:0];
                    start_d = 1'b1;
                    st_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cal_done) begin
                    res_d = cal_result;
                    // Only DC-offset and gain registers here; AC offsets
                    // live in the datapath's own registers
                    upd_d = {gsel & sel_q[4], gsel & sel_q[3],
                        ~gsel & ~sel_q[2] & sel_q[4],
                        ~gsel & ~sel_q[2] & sel_q[3]};
                    rdy_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= ST_IDLE;
            sel_q <= 5'h00;
            start_q <= 1'b0;
            upd_q <= 4'h0;
            res_q <= 24'h00_0000;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            sel_q <= sel_d;
            start_q <= start_d;
            upd_q <= upd_d;
            res_q <= res_d;
            rdy_q <= rdy_d;
        end
    end
    assign cal_start = start_q;
    assign cal_curr = sel_q[3];
    assign cal_volt = sel_q[4];
    assign cal_ac = sel_q[2];
    assign cal_gain = gsel;
    assign {gain_wr_v, gain_wr_i, offset_wr_v, offset_wr_i} = upd_q;
    assign cal_wr_data = res_q;
    assign result_ready_flag = rdy_q;

    // ----------------------------------------
    // Clock divider
    // ----------------------------------------
    logic [4:0] div_cnt_q, div_cnt_d;
    logic [4:0] ratio;
    logic [3:0] k_last_q;
    logic divided_internal_clk_q, divided_internal_clk_d, en_q, en_d, rst_cyc_q, rst_cyc_d;
    // Ratio follows the field latched at the last boundary
    assign ratio = (k_last_q == 4'h0) ? K_ZERO_MEANS_16
        : {1'b0, k_last_q};
    always_comb begin
        div_cnt_d = div_cnt_q + 5'h01;
        en_d = 1'b0;
        divided_internal_clk_d = divided_internal_clk_q;
        rst_cyc_d = 1'b0;
        // Ratio changes only at a period boundary, so no runt pulse
        if (div_cnt_q + 5'h01 >= ratio) begin
            div_cnt_d = 5'h00;
            en_d = 1'b1;
            divided_internal_clk_d = 1'b1;
            rst_cyc_d = (k_last_q != cfg_q[K_HI:K_LO]);
        end else if (div_cnt_q + 5'h01 >= (ratio >> 1)) begin
            divided_internal_clk_d = 1'b0;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            div_cnt_q <= 5'h00;
            divided_internal_clk_q <= 1'b0;
            en_q <= 1'b0;
            rst_cyc_q <= 1'b0;
            k_last_q <= CFG_RESET[K_HI:K_LO];
        end else begin
            div_cnt_q <= div_cnt_d;
            divided_internal_clk_q <= divided_internal_clk_d;
            en_q <= en_d;
            rst_cyc_q <= rst_cyc_d;
            if (en_d) begin
                k_last_q <= cfg_q[K_HI:K_LO];
            end
        end
    end
    assign divided_clk_en = en_q;
    assign cycle_restart = rst_cyc_q;
    // Ratio one: divided clock output follows the enable, which is always high
    assign divided_internal_clk = (ratio == 5'h01) ? en_q : divided_internal_clk_q;
    assign host_clock_out =
        divided_internal_clk ^ cfg_q[CLK_INV_BIT];

    // ----------------------------------------
    // Energy pulse pins
    // ----------------------------------------
    logic pa_lvl, pb_lvl;
    always_comb begin
        pa_lvl = pulse_a_raw_n;
        pb_lvl = pulse_b_raw_n;
        if (cfg_q[OVR_EN_BIT]) begin
            pa_lvl = cfg_q[OVR_A_BIT];
            pb_lvl = cfg_q[OVR_B_BIT];
        end
    end
    always_comb begin
        energy_pulse_a_n_o = pa_lvl;
        energy_pulse_b_n_o = pb_lvl;
        energy_pulse_a_n_oe = 1'b1;
        energy_pulse_b_n_oe = 1'b1;
        if (cfg_q[OPEN_DRAIN_BIT]) begin
            energy_pulse_a_n_o = 1'b0;
            energy_pulse_b_n_o = 1'b0;
            energy_pulse_a_n_oe = ~pa_lvl;
            energy_pulse_b_n_oe = ~pb_lvl;
        end
    end

    // ----------------------------------------
    // Interrupt pin style
    // ----------------------------------------
    logic irq_prev_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_prev_q <= 1'b0;
        end else begin
            irq_prev_q <= irq_event;
        end
    end
    always_comb begin
        unique case ({cfg_q[IRQ_STYLE_BIT], cfg_q[IRQ_POL_BIT]})
            2'b00: irq_pin = ~irq_event;
            2'b01: irq_pin = irq_event;
            2'b10: irq_pin = ~(irq_event & ~irq_prev_q);
            2'b11: irq_pin = irq_event & ~irq_prev_q;
        endcase
    end
endmodule
`default_nettype wire

// File: tb/mcc_config_cal_properties.sv
`timescale 1ns/1ns
`default_nettype none
module mcc_config_cal_checker
    import mcc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command side
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic wr_commit,
    input wire logic [4:0] wr_addr,
    input wire logic [23:0] wr_data,
    input wire logic cal_done,
    input wire logic irq_event,
    // Outputs
    input wire logic [23:0] cfg_rd_data,
    input wire logic cal_start,
    input wire logic result_ready_flag,
    input wire logic [6:0] phase_comp,
    input wire logic curr_gain_50x,
    input wire logic counter_drive_mode,
    input wire logic energy_pulse_a_n_o,
    input wire logic energy_pulse_b_n_o,
    input wire logic irq_pin
);
    logic [23:0] c;
    assign c = cfg_rd_data;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_cfg_write_lands: assert property (
        wr_commit && wr_addr == 5'h00 |=>
        c == ($past(wr_data) & CFG_WRITABLE))
        else $error("config write lost");
    a_cfg_reset_value: assert property (
        $fell(rst) |-> c == CFG_RESET)
        else $error("config reset value wrong");
    a_cal_prefix_only: assert property (
        cmd_valid && cmd_byte[7:5] != 3'h6 |=> !cal_start)
        else $error("non calibration command started one");
    a_start_single: assert property (
        cal_start |=> !cal_start)
        else $error("start longer than one cycle");
    a_flag_on_done: assert property (
        cal_done |=> result_ready_flag)
        else $error("ready flag not set");
    a_field_copy: assert property (
        phase_comp == c[PC_HI:PC_LO] && curr_gain_50x == c[IGAIN_BIT])
        else $error("field mismatch");
    a_open_drain_low: assert property (
        c[OPEN_DRAIN_BIT] |-> !energy_pulse_a_n_o && !energy_pulse_b_n_o)
        else $error("open drain high");
    a_override_level: assert property (
        c[OVR_EN_BIT] && !c[OPEN_DRAIN_BIT] |->
        energy_pulse_a_n_o == c[OVR_A_BIT] &&
        energy_pulse_b_n_o == c[OVR_B_BIT])
        else $error("override level wrong");
    a_irq_level: assert property (
        !c[IRQ_STYLE_BIT] |-> irq_pin == (irq_event ^ !c[IRQ_POL_BIT]))
        else $error("irq level wrong");
    a_irq_pulse: assert property (
        c[IRQ_STYLE_BIT] |->
        irq_pin == ((irq_event && !$past(irq_event)) ^ !c[IRQ_POL_BIT]))
        else $error("irq pulse wrong");
    a_swing_counter: assert property (
        c[SWING_BIT] |-> counter_drive_mode)
        else $error("counter drive missing");
endmodule
bind mcc_config_cal mcc_config_cal_checker chk_u (.*);
`default_nettype wire

// File: tb/mcc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcc_host_model
    import mcc_pkg::*;
(
    // Clock
    input wire logic clock,
    // Decoded command port
    output logic cmd_valid = 1'b0,
    output logic [7:0] cmd_byte = 8'h00,
    output logic wr_commit = 1'b0,
    output logic [4:0] wr_addr = 5'h00,
    output logic [23:0] wr_data = 24'h00_0000
);
    // Released data and command-byte buses flip so stale values never look valid; wr_addr keeps its value
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clock);
        wr_commit <= 1'b1;
        wr_addr <= a;
        wr_data <= d & CFG_WRITABLE;
        @(posedge clock);
        wr_commit <= 1'b0;
        wr_data <= ~wr_data;
    endtask
    task automatic cmd(input logic [7:0] b);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_byte <= ~b;
    endtask
endmodule
`default_nettype wire

// File: tb/meter_config_and_calibration_cmd_bench.sv
`timescale 1ns/1ns
`default_nettype none
module meter_config_and_calibration_cmd_bench;
    import mcc_pkg::*;
    logic clock = 1'b0, rst = 1'b1, cal_done = 1'b0, result_ready_clr = 1'b0;
    logic irq_event = 1'b0, pulse_a_raw_n = 1'b1, pulse_b_raw_n = 1'b1;
    logic [23:0] cal_result = 24'h00_0000, cfg_rd_data, cal_wr_data;
    logic [23:0] wr_data, w;
    logic pv;
    logic [7:0] cmd_byte;
    logic [6:0] phase_comp;
    logic [4:0] wr_addr;
    logic cmd_valid, wr_commit, cal_start, cal_curr, cal_volt, cal_gain, cal_ac;
    logic offset_wr_i, offset_wr_v, gain_wr_i, gain_wr_v, result_ready_flag;
    logic curr_gain_50x, volt_highpass_en, curr_highpass_en, cycle_restart;
    logic swinging_pulse_format, counter_drive_mode, divided_internal_clk;
    logic divided_clk_en, host_clock_out, irq_pin;
    logic energy_pulse_a_n_o, energy_pulse_a_n_oe;
    logic energy_pulse_b_n_o, energy_pulse_b_n_oe;
    logic [4:0] codes [11] = '{5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h11, 5'h12,
        5'h15, 5'h16, 5'h19, 5'h1A, 5'h1D};
    logic [3:0] ks [4] = '{4'h1, 4'h3, 4'h4, 4'h0};
    int seed = 10, n_mismatch = 0, checks_done = 0, cnt, nr, kv, hi;
    mcc_config_cal dut_u (.*);
    mcc_host_model host_u (.*);
    always #5 clock = ~clock;
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic is_gain(input logic [4:0] c);
        return c[1] || c == CAL_B_AC_GAIN;
    endfunction
    function automatic logic [3:0] upd(input logic [4:0] c);
        return {c[3] & ~is_gain(c) & ~c[2], c[4] & ~is_gain(c) & ~c[2],
            c[3] & is_gain(c), c[4] & is_gain(c)};
    endfunction
    function automatic logic [1:0] pin_exp(input logic [23:0] c,
        input logic raw, input logic ovr);
        logic l;
        l = c[OVR_EN_BIT] ? ovr : raw;
        return c[OPEN_DRAIN_BIT] ? {1'b0, ~l} : {l, 1'b1};
    endfunction
    task automatic cal(input logic [4:0] c);
        int n;
        logic [23:0] r;
        n = 0;
        r = 24'($random(seed));
        host_u.cmd({3'h6, c});
        #1;
        while (cal_start !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(n < 8 && {cal_volt, cal_curr, cal_ac, cal_gain} ===
            {c[4:2], is_gain(c)}, "sel");
        @(posedge clock);
        cal_done <= 1'b1;
        cal_result <= r;
        @(posedge clock);
        cal_done <= 1'b0;
        cal_result <= ~r;
        #1;
        chk(result_ready_flag === 1'b1, "ready");
        chk({offset_wr_i, offset_wr_v, gain_wr_i, gain_wr_v,
            cal_wr_data} === {upd(c), r}, "update");
        @(posedge clock);
        result_ready_clr <= 1'b1;
        @(posedge clock);
        result_ready_clr <= 1'b0;
        #1;
        chk(result_ready_flag === 1'b0, "clear");
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk(cfg_rd_data === CFG_RESET, "reset value");
        for (int i = 0; i < 8; i++) begin
            w = 24'($random(seed));
            host_u.wr(5'h00, w);
            #1;
            chk(cfg_rd_data === (w & CFG_WRITABLE), "write");
            chk({phase_comp, curr_gain_50x, swinging_pulse_format,
                volt_highpass_en, curr_highpass_en} === {w[PC_HI:PC_LO],
                w[IGAIN_BIT], w[SWING_BIT], w[VOLT_HIGHPASS_EN_BIT],
                w[CURR_HIGHPASS_EN_BIT]}, "fields");
            chk({energy_pulse_a_n_o, energy_pulse_a_n_oe, energy_pulse_b_n_o,
                energy_pulse_b_n_oe} === {pin_exp(w, pulse_a_raw_n,
                w[OVR_A_BIT]), pin_exp(w, pulse_b_raw_n, w[OVR_B_BIT])},
                "pins");
            chk(host_clock_out === (divided_internal_clk ^ w[CLK_INV_BIT]),
                "host clock");
            host_u.wr(5'h01, ~w);
            #1;
            chk(cfg_rd_data === (w & CFG_WRITABLE), "other addr");
            repeat (4) begin
                @(posedge clock);
                pulse_a_raw_n <= 1'($random(seed));
                pulse_b_raw_n <= 1'($random(seed));
                irq_event <= 1'($random(seed));
            end
        end
        $display("config test done");
        foreach (codes[j]) begin
            cal(codes[j]);
        end
        host_u.cmd(8'hE0);
        #1;
        chk(cal_start === 1'b0, "non cal");
        $display("calibration test done");
        foreach (ks[j]) begin
            nr = (w[K_HI:K_LO] != ks[j]);
            w = {20'h0_0000, ks[j]};
            kv = (ks[j] == 4'h0) ? 16 : int'(ks[j]);
            host_u.wr(5'h00, w);
            cnt = 0;
            repeat (40) begin
                @(posedge clock);
                #1;
                cnt += cycle_restart;
            end
            chk(cnt == nr, "restart");
            cnt = 0;
            hi = 0;
            pv = divided_internal_clk;
            repeat (48) begin
                @(posedge clock);
                #1;
                cnt += divided_clk_en;
                hi += (kv == 1) ? divided_internal_clk
                    : (divided_internal_clk & ~pv);
                pv = divided_internal_clk;
            end
            chk(cnt == 48 / kv, "divider");
            chk(hi == 48 / kv, "internal clock");
        end
        chk(energy_pulse_a_n_oe === 1'b1 &&
            energy_pulse_a_n_o === pulse_a_raw_n, "push pull");
        $display("divider test done");
        print_verdict;
    end
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
endmodule
`default_nettype wire
